// >>> hw/csic_core.sv
// Register file, pointers, stack pointer and interrupt vectoring of the core.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1: Working registers occupy data addresses zero to 31.
// RQ2: Read and writeback ports in 8/16-bit combinations.
// RQ3: Top six registers form three pointer pairs.
// RQ4: Pointer access with displacement, postincrement, predecrement.
// RQ5: Stack grows downward, pointer marks the top.
// RQ6: Push/pop move pointer by one or two.
// RQ7: Stack pointer bytes readable, writable, reset zero.
// RQ8: Software sets stack pointer before calls/interrupts.
// RQ9: Software masks unused return address bits.
// RQ10: Single clock, one-cycle register operand writeback.
// RQ11: Take interrupt only with own and global enable.
// RQ12: Lower vector index means higher priority.
// RQ13: Vector select and fuse relocate to boot start.
// RQ14: Boot lock bits suppress interrupts by PC.
// RQ15: Entry clears global enable, return sets it.
// RQ16: Handler setting global enable allows nesting.
// RQ17: Vectoring or writing one clears the flag.
// RQ18: Disabled flags stay pending, served by priority.
// RQ19: Level sources request only while present.
// RQ20: One main instruction runs after each return.
// RQ21: Software saves status register in handlers.
// RQ22: Global disable blocks even a coincident interrupt.
// RQ23: Instruction after global enable runs first.
// RQ24: Entry takes four cycles, pushes the PC.
// RQ25: Return takes four cycles, pops two bytes.
module csic_core (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] rf_rd_addr_a,
  input wire logic [4:0] rf_rd_addr_b,
  output logic [7:0] rf_rd_data_a,
  output logic [7:0] rf_rd_data_b,
  output logic [15:0] rf_rd_data_w,
  input wire logic rf_wb_en,
  input wire logic rf_wb_wide,
  input wire logic [4:0] rf_wb_addr,
  input wire logic [15:0] rf_wb_data,
  input wire logic ptr_go,
  input wire csic_pkg::csic_ptr_t ptr_sel,
  input wire csic_pkg::csic_amode_t ptr_mode,
  input wire logic [5:0] ptr_disp,
  output logic [15:0] ptr_addr,
  input wire logic ds_en,
  input wire logic ds_we,
  input wire logic [15:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  output logic ds_hit,
  output logic [7:0] ds_rdata,
  output logic ds_rvalid,
  input wire logic stk_op_en,
  input wire csic_pkg::csic_skop_t stk_op,
  output logic [15:0] sp_value,
  input wire logic instr_done,
  input wire logic sei_exec,
  input wire logic cli_exec,
  input wire logic interrupt_return_instr_exec,
  input wire logic [15:0] pc_current,
  input wire logic [2:0] irq_event,
  input wire logic irq_level,
  input wire logic boot_reset_fuse,
  input wire logic app_lock_bit,
  input wire logic boot_lock_bit,
  output logic gie,
  output logic core_busy,
  output logic irq_taken,
  output logic vec_valid,
  output logic [15:0] vec_addr,
  output logic ret_valid,
  output logic [15:0] ret_pc,
  output logic [15:0] reset_vector,
  output logic stk_we,
  output logic stk_re,
  output logic [15:0] stk_addr,
  output logic [7:0] stk_wdata,
  input wire logic [7:0] stk_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic [7:0] regs_ff [32];
  logic [15:0] sp_ff;
  logic gie_ff;
  logic [3:0] en_ff;
  logic vsel_ff;
  logic [2:0] flag_ff;
  logic [1:0] src_ff;
  logic [15:0] vec_ff;
  logic [15:0] pcsave_ff;
  logic [15:0] retpc_ff;
  logic [15:0] rstvec_ff;
  logic [7:0] ds_rdata_ff;
  logic ds_rvalid_ff;
  csic_pkg::csic_state_t state_ff;
  csic_pkg::csic_state_t nxt_state;

  function automatic logic [15:0] pair_of(input logic [4:0] idx);
    pair_of = {regs_ff[{idx[4:1], 1'b1}], regs_ff[{idx[4:1], 1'b0}]};
  endfunction

  function automatic logic [1:0] first_of(input logic [3:0] req);
    first_of = 2'h3;
    for (int i = csic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        first_of = i[1:0];
      end
    end
  endfunction

  function automatic logic [15:0] vec_ofs(input logic [1:0] src);
    vec_ofs = csic_pkg::VEC_STRIDE * ({14'h0000, src} + 16'h0001);
  endfunction

  // Register file reads are combinational so an ALU operation closes in one cycle.
  assign rf_rd_data_a = regs_ff[rf_rd_addr_a]; // RQ2 RQ10
  assign rf_rd_data_b = regs_ff[rf_rd_addr_b]; // RQ2
  assign rf_rd_data_w = pair_of(rf_rd_addr_a); // RQ2

  // Pointer pairs and their addressing forms.
  logic [4:0] ptr_idx;
  logic [15:0] ptr_base;
  logic [15:0] ptr_next;
  always_comb begin
    unique case (ptr_sel)
      csic_pkg::CSIC_PTR_X: ptr_idx = csic_pkg::PTR_X_IDX; // RQ3
      csic_pkg::CSIC_PTR_Y: ptr_idx = csic_pkg::PTR_Y_IDX; // RQ3
      default: ptr_idx = csic_pkg::PTR_Z_IDX; // RQ3
    endcase
    ptr_base = pair_of(ptr_idx);
    ptr_next = ptr_base;
    ptr_addr = ptr_base;
    unique case (ptr_mode)
      csic_pkg::CSIC_AM_PLAIN: ptr_addr = ptr_base;
      csic_pkg::CSIC_AM_DISP: ptr_addr = ptr_base + {10'h000, ptr_disp}; // RQ4
      csic_pkg::CSIC_AM_POSTINC: ptr_next = ptr_base + 16'h0001; // RQ4
      csic_pkg::CSIC_AM_PREDEC: begin
        ptr_next = ptr_base - 16'h0001; // RQ4
        ptr_addr = ptr_next;
      end
    endcase
  end

  // Data-space decode.
  logic rf_sel;
  logic ds_wr;
  assign rf_sel = ds_addr < csic_pkg::RF_LIMIT; // RQ1
  assign ds_hit = rf_sel || ds_addr == csic_pkg::IFLAG_ADDR || ds_addr == csic_pkg::GIC_ADDR
                  || ds_addr == csic_pkg::SP_LOW_ADDR || ds_addr == csic_pkg::SP_HIGH_ADDR
                  || ds_addr == csic_pkg::FLAGS_ADDR;
  assign ds_wr = ds_en && ds_we;

  // A pointer update wins over a writeback or store to the same register in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        regs_ff[i] <= 8'h00;
      end
    end else begin
      if (rf_wb_en) begin
        if (rf_wb_wide) begin
          regs_ff[{rf_wb_addr[4:1], 1'b0}] <= rf_wb_data[7:0]; // RQ2
          regs_ff[{rf_wb_addr[4:1], 1'b1}] <= rf_wb_data[15:8]; // RQ2
        end else begin
          regs_ff[rf_wb_addr] <= rf_wb_data[7:0]; // RQ2 RQ10
        end
      end
      if (ds_wr && rf_sel) begin
        regs_ff[ds_addr[4:0]] <= ds_wdata; // RQ1
      end
      if (ptr_go && (ptr_mode == csic_pkg::CSIC_AM_POSTINC
                     || ptr_mode == csic_pkg::CSIC_AM_PREDEC)) begin
        regs_ff[ptr_idx] <= ptr_next[7:0]; // RQ4
        regs_ff[ptr_idx + 5'h01] <= ptr_next[15:8]; // RQ4
      end
    end
  end

  // Interrupt requests and the decision to take one.
  logic [3:0] req;
  logic lock_block;
  logic take;
  logic in_boot;
  assign req = {irq_level, flag_ff} & en_ff; // RQ11 RQ18 RQ19
  assign in_boot = pc_current >= csic_pkg::BOOT_START;
  // Vectors in the other section may not be reached from a locked section.
  assign lock_block = (app_lock_bit && !in_boot && vsel_ff)
                      || (boot_lock_bit && in_boot && !vsel_ff); // RQ14
  // The registered enable makes the instruction after a global enable run first.
  assign take = state_ff == csic_pkg::CSIC_IDLE && instr_done && gie_ff && !cli_exec
                && !interrupt_return_instr_exec && !lock_block && |req; // RQ11 RQ16 RQ20 RQ22 RQ23 RQ24
  assign irq_taken = take;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      src_ff <= 2'h0;
      vec_ff <= csic_pkg::APP_START;
      pcsave_ff <= 16'h0000;
    end else if (take) begin
      src_ff <= first_of(req); // RQ12 RQ18
      vec_ff <= (vsel_ff ? csic_pkg::BOOT_START : csic_pkg::APP_START)
                + vec_ofs(first_of(req)); // RQ12 RQ13
      pcsave_ff <= pc_current; // RQ24
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rstvec_ff <= csic_pkg::APP_START;
    end else begin
      rstvec_ff <= boot_reset_fuse ? csic_pkg::BOOT_START : csic_pkg::APP_START; // RQ13
    end
  end
  assign reset_vector = rstvec_ff;

  // Latched flags: a new event beats a clear in the same cycle.
  logic [2:0] flag_clr;
  assign flag_clr = ((ds_wr && ds_addr == csic_pkg::IFLAG_ADDR) ? ds_wdata[2:0] : 3'h0)
                    | ((take && first_of(req) != 2'h3) ? 3'(3'h1 << first_of(req)) : 3'h0);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flag_ff <= csic_pkg::FLAG_RESET;
    end else begin
      flag_ff <= (flag_ff & ~flag_clr) | irq_event; // RQ17 RQ18
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      en_ff <= csic_pkg::EN_RESET;
      vsel_ff <= 1'b0;
    end else if (ds_wr && ds_addr == csic_pkg::GIC_ADDR) begin
      en_ff <= ds_wdata[csic_pkg::EN_LSB +: csic_pkg::NUM_SRC]; // RQ11
      vsel_ff <= ds_wdata[csic_pkg::VSEL_BIT]; // RQ13
    end
  end

  // Global enable; a coincident disable is honoured before the take.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gie_ff <= 1'b0;
    end else if (take || cli_exec) begin
      gie_ff <= 1'b0; // RQ15 RQ22
    end else if (state_ff == csic_pkg::CSIC_RET4 || sei_exec) begin
      gie_ff <= 1'b1; // RQ15 RQ16 RQ25
    end else if (ds_wr && ds_addr == csic_pkg::FLAGS_ADDR) begin
      gie_ff <= ds_wdata[csic_pkg::GIE_BIT]; // RQ16
    end
  end
  assign gie = gie_ff;

  // Entry and return sequencer.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      csic_pkg::CSIC_IDLE: begin
        if (take) begin
          nxt_state = csic_pkg::CSIC_ENT1;
        end else if (interrupt_return_instr_exec) begin
          nxt_state = csic_pkg::CSIC_RET1;
        end
      end
      csic_pkg::CSIC_ENT1: nxt_state = csic_pkg::CSIC_ENT2;
      csic_pkg::CSIC_ENT2: nxt_state = csic_pkg::CSIC_ENT3;
      csic_pkg::CSIC_ENT3: nxt_state = csic_pkg::CSIC_ENT4;
      csic_pkg::CSIC_RET1: nxt_state = csic_pkg::CSIC_RET2;
      csic_pkg::CSIC_RET2: nxt_state = csic_pkg::CSIC_RET3;
      csic_pkg::CSIC_RET3: nxt_state = csic_pkg::CSIC_RET4;
      default: nxt_state = csic_pkg::CSIC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= csic_pkg::CSIC_IDLE;
    end else begin
      state_ff <= nxt_state; // RQ24 RQ25
    end
  end

  assign core_busy = state_ff != csic_pkg::CSIC_IDLE;
  assign stk_we = state_ff == csic_pkg::CSIC_ENT1 || state_ff == csic_pkg::CSIC_ENT2; // RQ24
  assign stk_re = state_ff == csic_pkg::CSIC_RET1 || state_ff == csic_pkg::CSIC_RET2; // RQ25
  assign stk_addr = stk_re ? sp_ff + 16'h0001 : sp_ff; // RQ5
  assign stk_wdata = state_ff == csic_pkg::CSIC_ENT1 ? pcsave_ff[7:0] : pcsave_ff[15:8];
  assign vec_valid = state_ff == csic_pkg::CSIC_ENT4; // RQ24
  assign vec_addr = vec_ff;
  assign ret_valid = state_ff == csic_pkg::CSIC_RET4; // RQ25
  assign ret_pc = retpc_ff;

  // Return address bytes arrive one cycle after each stack read.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      retpc_ff <= 16'h0000;
    end else if (state_ff == csic_pkg::CSIC_RET2) begin
      retpc_ff[15:8] <= stk_rdata; // RQ25
    end else if (state_ff == csic_pkg::CSIC_RET3) begin
      retpc_ff[7:0] <= stk_rdata; // RQ25
    end
  end

  // Stack pointer: sequencer first, then software stores, then instruction stack ops.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sp_ff <= csic_pkg::SP_RESET; // RQ7
    end else if (stk_we) begin
      sp_ff <= sp_ff - 16'h0001; // RQ6 RQ24
    end else if (stk_re) begin
      sp_ff <= sp_ff + 16'h0001; // RQ6 RQ25
    end else if (ds_wr && ds_addr == csic_pkg::SP_LOW_ADDR) begin
      sp_ff[7:0] <= ds_wdata; // RQ7
    end else if (ds_wr && ds_addr == csic_pkg::SP_HIGH_ADDR) begin
      sp_ff[15:8] <= ds_wdata; // RQ7
    end else if (stk_op_en) begin
      unique case (stk_op)
        csic_pkg::CSIC_SK_PUSH1: sp_ff <= sp_ff - 16'h0001; // RQ5 RQ6
        csic_pkg::CSIC_SK_PUSH2: sp_ff <= sp_ff - 16'h0002; // RQ6
        csic_pkg::CSIC_SK_POP1: sp_ff <= sp_ff + 16'h0001; // RQ6
        csic_pkg::CSIC_SK_POP2: sp_ff <= sp_ff + 16'h0002; // RQ6
      endcase
    end
  end
  assign sp_value = sp_ff;

  // Registered read data for the data-space port, zero for unmapped addresses.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (rf_sel) begin
      rd_mux = regs_ff[ds_addr[4:0]]; // RQ1
    end else if (ds_addr == csic_pkg::SP_LOW_ADDR) begin
      rd_mux = sp_ff[7:0]; // RQ7
    end else if (ds_addr == csic_pkg::SP_HIGH_ADDR) begin
      rd_mux = sp_ff[15:8]; // RQ7
    end else if (ds_addr == csic_pkg::FLAGS_ADDR) begin
      rd_mux[csic_pkg::GIE_BIT] = gie_ff;
    end else if (ds_addr == csic_pkg::GIC_ADDR) begin
      rd_mux = {en_ff, 2'h0, vsel_ff, 1'b0};
    end else if (ds_addr == csic_pkg::IFLAG_ADDR) begin
      rd_mux = {4'h0, irq_level, flag_ff};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ds_rdata_ff <= 8'h00;
      ds_rvalid_ff <= 1'b0;
    end else begin
      ds_rdata_ff <= rd_mux;
      ds_rvalid_ff <= ds_en && !ds_we;
    end
  end
  assign ds_rdata = ds_rdata_ff;
  assign ds_rvalid = ds_rvalid_ff;

  a_entry_sp_two: assert property (take |-> ##3 sp_ff == $past(sp_ff, 3) - 16'h0002) // RQ6
    else $error("Entry did not lower the stack pointer by two.");
  a_entry_vec_four: assert property (take |=> !vec_valid [*3] ##1 vec_valid) // RQ24
    else $error("Vector not presented four cycles after entry.");
  a_entry_clr_gie: assert property (take |=> !gie_ff) // RQ15
    else $error("Global enable survived interrupt entry.");
  a_cli_no_take: assert property (cli_exec |-> !irq_taken) // RQ22
    else $error("Interrupt taken with a coincident global disable.");
  a_sei_no_take: assert property (sei_exec && !gie_ff |-> !irq_taken) // RQ20 RQ23
    else $error("Interrupt taken before one instruction after enable.");
  a_take_enabled: assert property (take |-> gie_ff && req[first_of(req)] && en_ff[first_of(req)]) // RQ11
    else $error("Interrupt taken without its enables.");
  a_ret_sets_gie: assert property (interrupt_return_instr_exec && state_ff == csic_pkg::CSIC_IDLE && !take
                                   |-> ##5 gie_ff && sp_ff == $past(sp_ff, 5) + 16'h0002) // RQ25
    else $error("Return did not restore enable and stack pointer.");
  a_flag_hw_clear: assert property (take && first_of(req) == 2'h0 && !irq_event[0]
                                    |=> !flag_ff[0]) // RQ17
    else $error("Flag not cleared on vectoring.");
  a_flag_set_wins: assert property (irq_event[0] |=> flag_ff[0]) // RQ17 RQ18
    else $error("Flag event lost.");
  a_prio_order: assert property (take && req[0] |=> src_ff == 2'h0) // RQ12
    else $error("Highest priority source not chosen.");
endmodule // csic_core

`default_nettype wire

// >>> hw/csic_pkg.sv
// Constants, map and types of the core stack and interrupt control block.
package csic_pkg;
  // Data-space map of the block: working registers first, then its I/O registers.
  localparam logic [15:0] RF_LIMIT = 16'h0020;
  localparam logic [15:0] IFLAG_ADDR = 16'h005a;
  localparam logic [15:0] GIC_ADDR = 16'h005b;
  localparam logic [15:0] SP_LOW_ADDR = 16'h005d;
  localparam logic [15:0] SP_HIGH_ADDR = 16'h005e;
  localparam logic [15:0] FLAGS_ADDR = 16'h005f;
  // Field positions.
  localparam int GIE_BIT = 7;
  localparam int VSEL_BIT = 1;
  localparam int EN_LSB = 4;
  localparam int LVL_STAT_BIT = 3;
  // Sources: three latched flags (index 0 is external request zero), one level source.
  localparam int NUM_SRC = 4;
  localparam int NUM_FLAG = 3;
  // Reset values.
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [3:0] EN_RESET = 4'h0;
  localparam logic [2:0] FLAG_RESET = 3'h0;
  // Vector table.
  localparam logic [15:0] BOOT_START = 16'h1c00;
  localparam logic [15:0] APP_START = 16'h0000;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  // Pointer pair base indices in the register file.
  localparam logic [4:0] PTR_X_IDX = 5'h1a;
  localparam logic [4:0] PTR_Y_IDX = 5'h1c;
  localparam logic [4:0] PTR_Z_IDX = 5'h1e;

  typedef enum logic [1:0] {
    CSIC_PTR_X = 2'h0,
    CSIC_PTR_Y = 2'h1,
    CSIC_PTR_Z = 2'h2
  } csic_ptr_t;

  typedef enum logic [1:0] {
    CSIC_AM_PLAIN = 2'h0,
    CSIC_AM_DISP = 2'h1,
    CSIC_AM_POSTINC = 2'h2,
    CSIC_AM_PREDEC = 2'h3
  } csic_amode_t;

  typedef enum logic [1:0] {
    CSIC_SK_PUSH1 = 2'h0,
    CSIC_SK_PUSH2 = 2'h1,
    CSIC_SK_POP1 = 2'h2,
    CSIC_SK_POP2 = 2'h3
  } csic_skop_t;

  typedef enum logic [8:0] {
    CSIC_IDLE = 9'h001,
    CSIC_ENT1 = 9'h002,
    CSIC_ENT2 = 9'h004,
    CSIC_ENT3 = 9'h008,
    CSIC_ENT4 = 9'h010,
    CSIC_RET1 = 9'h020,
    CSIC_RET2 = 9'h040,
    CSIC_RET3 = 9'h080,
    CSIC_RET4 = 9'h100
  } csic_state_t;
endpackage

// >>> hw/csic_unused.sv
// Holds no logic; all logic of the block lives in the core file, its constants and types in the package file.

// >>> testbench/csic_stack_mem.sv
// Behavioural stack memory that answers the block's stack port.
`timescale 1ns/1ps
`default_nettype none
module csic_stack_mem (
  input wire logic ref_clk,
  input wire logic stk_we,
  input wire logic stk_re,
  input wire logic [15:0] stk_addr,
  input wire logic [7:0] stk_wdata,
  output logic [7:0] stk_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] rd_ff = 8'h5a;
  // Outside a read the bus toggles every cycle, so a late or early capture is caught.
  always @(posedge ref_clk) begin
    if (stk_we) begin
      mem[stk_addr[7:0]] <= stk_wdata;
    end
    rd_ff <= stk_re ? mem[stk_addr[7:0]] : ~rd_ff;
  end
  assign stk_rdata = rd_ff;
endmodule // csic_stack_mem
`default_nettype wire

// >>> testbench/cpu_stack_and_interrupt_control_tb.sv
// Self-checking testbench of the core stack and interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_and_interrupt_control_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] rf_rd_addr_a = 5'h00, rf_rd_addr_b = 5'h00, rf_wb_addr = 5'h00;
  logic [7:0] rf_rd_data_a, rf_rd_data_b, ds_rdata, ds_wdata = 8'h00;
  logic [15:0] rf_rd_data_w, rf_wb_data = 16'h0000, ptr_addr, ds_addr = 16'h0000;
  logic rf_wb_en = 1'b0, rf_wb_wide = 1'b0, ptr_go = 1'b0, ds_en = 1'b0, ds_we = 1'b0;
  csic_pkg::csic_ptr_t ptr_sel = csic_pkg::CSIC_PTR_X;
  csic_pkg::csic_amode_t ptr_mode = csic_pkg::CSIC_AM_PLAIN;
  csic_pkg::csic_skop_t stk_op = csic_pkg::CSIC_SK_PUSH1;
  logic [5:0] ptr_disp = 6'h00;
  logic ds_hit, ds_rvalid, stk_op_en = 1'b0, gie, core_busy, irq_taken, vec_valid, ret_valid;
  logic [15:0] sp_value, vec_addr, ret_pc, reset_vector, stk_addr, pc_current = 16'h0000;
  logic instr_done = 1'b0, sei_exec = 1'b0, cli_exec = 1'b0, interrupt_return_instr_exec = 1'b0;
  logic [2:0] irq_event = 3'h0;
  logic irq_level = 1'b0, boot_reset_fuse = 1'b1, app_lock_bit = 1'b0, boot_lock_bit = 1'b0;
  logic stk_we, stk_re;
  logic [7:0] stk_wdata, stk_rdata;
  int errors = 0;
  int samples_checked = 0;
  int n;

  always #10 ref_clk = ~ref_clk;

  csic_core u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .rf_rd_addr_a(rf_rd_addr_a),
    .rf_rd_addr_b(rf_rd_addr_b), .rf_rd_data_a(rf_rd_data_a), .rf_rd_data_b(rf_rd_data_b),
    .rf_rd_data_w(rf_rd_data_w), .rf_wb_en(rf_wb_en), .rf_wb_wide(rf_wb_wide),
    .rf_wb_addr(rf_wb_addr), .rf_wb_data(rf_wb_data), .ptr_go(ptr_go), .ptr_sel(ptr_sel),
    .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .ptr_addr(ptr_addr), .ds_en(ds_en),
    .ds_we(ds_we), .ds_addr(ds_addr), .ds_wdata(ds_wdata), .ds_hit(ds_hit),
    .ds_rdata(ds_rdata), .ds_rvalid(ds_rvalid), .stk_op_en(stk_op_en), .stk_op(stk_op),
    .sp_value(sp_value), .instr_done(instr_done), .sei_exec(sei_exec), .cli_exec(cli_exec),
    .interrupt_return_instr_exec(interrupt_return_instr_exec), .pc_current(pc_current), .irq_event(irq_event),
    .irq_level(irq_level), .boot_reset_fuse(boot_reset_fuse), .app_lock_bit(app_lock_bit),
    .boot_lock_bit(boot_lock_bit), .gie(gie), .core_busy(core_busy), .irq_taken(irq_taken),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .ret_valid(ret_valid), .ret_pc(ret_pc),
    .reset_vector(reset_vector), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

  csic_stack_mem u_mem (.ref_clk(ref_clk), .stk_we(stk_we), .stk_re(stk_re),
    .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic ds_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ds_en = 1'b1; ds_we = 1'b1; ds_addr = a; ds_wdata = d;
    @(negedge ref_clk);
    ds_en = 1'b0; ds_we = 1'b0;
  endtask

  task automatic ds_rd(input logic [15:0] a, input logic [7:0] exp, input logic hit);
    @(negedge ref_clk);
    ds_en = 1'b1; ds_addr = a;
    #1 chk("ds_hit", {15'h0000, ds_hit}, {15'h0000, hit});
    @(negedge ref_clk);
    ds_en = 1'b0;
    chk("ds_rvalid", {15'h0000, ds_rvalid}, 16'h0001);
    chk("ds_rdata", {8'h00, ds_rdata}, {8'h00, exp});
  endtask

  task automatic wb(input logic [4:0] a, input logic [15:0] d, input logic wide);
    @(negedge ref_clk);
    rf_wb_en = 1'b1; rf_wb_addr = a; rf_wb_data = d; rf_wb_wide = wide;
    @(negedge ref_clk);
    rf_wb_en = 1'b0; rf_rd_addr_a = a;
    #1;
  endtask

  task automatic ptr(input csic_pkg::csic_ptr_t s, input csic_pkg::csic_amode_t m,
                     input logic [5:0] d, input logic [4:0] idx, input logic [15:0] ea,
                     input logic [15:0] aft);
    @(negedge ref_clk);
    ptr_go = 1'b1; ptr_sel = s; ptr_mode = m; ptr_disp = d;
    #1 chk("ptr_addr", ptr_addr, ea);
    @(negedge ref_clk);
    ptr_go = 1'b0; rf_rd_addr_a = idx;
    #1 chk("pointer pair", rf_rd_data_w, aft);
  endtask

  task automatic stk(input csic_pkg::csic_skop_t op, input logic [15:0] exp);
    @(negedge ref_clk);
    stk_op_en = 1'b1; stk_op = op;
    @(negedge ref_clk);
    stk_op_en = 1'b0;
    chk("sp_value", sp_value, exp);
  endtask

  // One instruction boundary; irq_taken is combinational, so it is sampled before the edge.
  task automatic instr(input logic s, input logic c, input logic r, input logic [15:0] pc,
                       input logic take);
    @(negedge ref_clk);
    instr_done = 1'b1; sei_exec = s; cli_exec = c; interrupt_return_instr_exec = r; pc_current = pc;
    #1 chk("irq_taken", {15'h0000, irq_taken}, {15'h0000, take});
    @(negedge ref_clk);
    instr_done = 1'b0; sei_exec = 1'b0; cli_exec = 1'b0; interrupt_return_instr_exec = 1'b0;
  endtask

  task automatic flag_event(input logic [2:0] f);
    @(negedge ref_clk);
    irq_event = f;
    @(negedge ref_clk);
    irq_event = 3'h0;
  endtask

  task automatic wait_vec(input logic [15:0] exp);
    n = 1;
    while (vec_valid !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    chk("vector latency", 16'(n), 16'h0004);
    chk("vec_addr", vec_addr, exp);
    chk("core_busy", {15'h0000, core_busy}, 16'h0001);
  endtask

  initial begin
    repeat (2000) @(posedge ref_clk);
    errors++;
    results();
  end

  initial begin
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    ds_rd(csic_pkg::SP_LOW_ADDR, 8'h00, 1'b1);
    ds_rd(csic_pkg::SP_HIGH_ADDR, 8'h00, 1'b1);
    chk("reset_vector", reset_vector, csic_pkg::BOOT_START);
    ds_rd(16'h0060, 8'h00, 1'b0);
    wb(5'h03, 16'h00a5, 1'b0);
    chk("rf_rd_data_a", {8'h00, rf_rd_data_a}, 16'h00a5);
    ds_wr(16'h0007, 8'h3c);
    rf_rd_addr_b = 5'h07;
    #1 chk("rf_rd_data_b", {8'h00, rf_rd_data_b}, 16'h003c);
    ds_rd(16'h001f, 8'h00, 1'b1);
    wb(csic_pkg::PTR_X_IDX, 16'h0100, 1'b1);
    chk("rf_rd_data_w", rf_rd_data_w, 16'h0100);
    wb(csic_pkg::PTR_Y_IDX, 16'h0200, 1'b1);
    wb(csic_pkg::PTR_Z_IDX, 16'h0300, 1'b1);
    ptr(csic_pkg::CSIC_PTR_X, csic_pkg::CSIC_AM_PREDEC, 6'h00, 5'h1a, 16'h00ff, 16'h00ff);
    ptr(csic_pkg::CSIC_PTR_Y, csic_pkg::CSIC_AM_POSTINC, 6'h00, 5'h1c, 16'h0200, 16'h0201);
    ptr(csic_pkg::CSIC_PTR_Z, csic_pkg::CSIC_AM_DISP, 6'h3f, 5'h1e, 16'h033f, 16'h0300);
    // Stack placed above the register and I/O region before anything is enabled.
    ds_wr(csic_pkg::SP_LOW_ADDR, 8'h00);
    ds_wr(csic_pkg::SP_HIGH_ADDR, 8'h04);
    chk("sp_value", sp_value, 16'h0400);
    stk(csic_pkg::CSIC_SK_PUSH1, 16'h03ff);
    stk(csic_pkg::CSIC_SK_PUSH2, 16'h03fd);
    stk(csic_pkg::CSIC_SK_POP1, 16'h03fe);
    stk(csic_pkg::CSIC_SK_POP2, 16'h0400);
    flag_event(3'h3);
    instr(1'b0, 1'b0, 1'b0, 16'h0050, 1'b0);
    ds_rd(csic_pkg::IFLAG_ADDR, 8'h03, 1'b1);
    ds_wr(csic_pkg::GIC_ADDR, 8'h30);
    instr(1'b1, 1'b0, 1'b0, 16'h0051, 1'b0);
    chk("gie", {15'h0000, gie}, 16'h0001);
    instr(1'b0, 1'b0, 1'b0, 16'h1234, 1'b1);
    chk("gie", {15'h0000, gie}, 16'h0000);
    wait_vec(csic_pkg::APP_START + csic_pkg::VEC_STRIDE);
    chk("sp after entry", sp_value, 16'h03fe);
    chk("pushed low", {8'h00, u_mem.mem[8'h00]}, 16'h0034);
    chk("pushed high", {8'h00, u_mem.mem[8'hff]}, 16'h0012);
    ds_rd(csic_pkg::IFLAG_ADDR, 8'h02, 1'b1);
    instr(1'b0, 1'b0, 1'b1, 16'h0002, 1'b0);
    n = 1;
    while (ret_valid !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    chk("return latency", 16'(n), 16'h0004);
    chk("ret_pc", ret_pc, 16'h1234);
    chk("masked return", ret_pc & 16'h1fff, 16'h1234);
    @(negedge ref_clk);
    chk("gie after return", {15'h0000, gie}, 16'h0001);
    chk("sp after return", sp_value, 16'h0400);
    // The pending second source is refused at the same boundary as the disable.
    instr(1'b0, 1'b1, 1'b0, 16'h0060, 1'b0);
    chk("gie after disable", {15'h0000, gie}, 16'h0000);
    ds_wr(csic_pkg::IFLAG_ADDR, 8'h02);
    ds_rd(csic_pkg::IFLAG_ADDR, 8'h00, 1'b1);
    instr(1'b1, 1'b0, 1'b0, 16'h0061, 1'b0);
    flag_event(3'h4);
    instr(1'b0, 1'b0, 1'b0, 16'h0062, 1'b0);
    ds_wr(csic_pkg::IFLAG_ADDR, 8'h04);
    ds_wr(csic_pkg::GIC_ADDR, 8'h12);
    flag_event(3'h1);
    app_lock_bit = 1'b1;
    instr(1'b0, 1'b0, 1'b0, 16'h0100, 1'b0);
    app_lock_bit = 1'b0;
    instr(1'b0, 1'b0, 1'b0, 16'h0100, 1'b1);
    wait_vec(csic_pkg::BOOT_START + csic_pkg::VEC_STRIDE);
    // The handler keeps the flags register itself, then re-enables so the level source nests.
    ds_rd(csic_pkg::FLAGS_ADDR, 8'h00, 1'b1);
    irq_level = 1'b1;
    ds_wr(csic_pkg::GIC_ADDR, 8'h82);
    ds_wr(csic_pkg::FLAGS_ADDR, 8'h80);
    instr(1'b0, 1'b0, 1'b0, 16'h1c10, 1'b1);
    wait_vec(csic_pkg::BOOT_START + 16'h0004 * csic_pkg::VEC_STRIDE);
    irq_level = 1'b0;
    ds_wr(csic_pkg::FLAGS_ADDR, 8'h80);
    instr(1'b0, 1'b0, 1'b0, 16'h1c11, 1'b0);
    repeat (3) @(negedge ref_clk);
    results();
  end
endmodule // cpu_stack_and_interrupt_control_tb
`default_nettype wire
